// ### pipe_defines.svh
`ifndef PIPE_DEFINES_SVH
`define PIPE_DEFINES_SVH
`define XLEN 32
`define RA_W 5
`define RF_DEPTH 32
`define A_CAUSE_W 7
`define BC2_MIN_SLIP 2'h2
`define REG_ZERO 5'h00
`define WORD_ZERO 32'h0000_0000
`endif

// ### pipe_pkg.sv
`include "pipe_defines.svh"
package pipe_pkg;
  typedef enum logic [2:0] {
    K_ALU, K_LOAD, K_MF_MUL, K_MF_SYS, K_COP2, K_COP2_BR, K_BRANCH
  } kind_t;

  typedef struct packed {
    logic valid;
    kind_t kind;
    logic [`RA_W-1:0] src_a;
    logic [`RA_W-1:0] src_b;
    logic [`RA_W-1:0] dst;
    logic wr;
    logic to_cop2;
    logic [`XLEN-1:0] data;
  } stage_t;

  function automatic logic hits(stage_t s, logic [`RA_W-1:0] src);
    hits = s.valid && s.wr && (s.dst == src) && (src != `REG_ZERO);
  endfunction : hits

  // result arrives only in the align stage
  function automatic logic late(stage_t s);
    late = (s.kind == K_LOAD) || (s.kind == K_MF_MUL) || (s.kind == K_MF_SYS) || (s.kind == K_COP2);
  endfunction : late
endpackage : pipe_pkg

// ### rf_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "pipe_defines.svh"
interface rf_if;
  logic [`RA_W-1:0] raddr_a;
  logic [`RA_W-1:0] raddr_b;
  logic [`XLEN-1:0] rdata_a;
  logic [`XLEN-1:0] rdata_b;
  logic we;
  logic [`RA_W-1:0] waddr;
  logic [`XLEN-1:0] wdata;
  modport core (output raddr_a, output raddr_b, input rdata_a, input rdata_b,
                output we, output waddr, output wdata);
  modport rf (input raddr_a, input raddr_b, output rdata_a, output rdata_b,
              input we, input waddr, input wdata);
endinterface : rf_if
`default_nettype wire

// ### reg_file.sv
`timescale 1ns/10ps
`default_nettype none
`include "pipe_defines.svh"
module reg_file (
  input wire logic clk, // pipeline clock
  input wire logic rst_n, // sync reset, low
  rf_if.rf port // read and write ports
);
  logic [`XLEN-1:0] mem_q [`RF_DEPTH];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `RF_DEPTH; i++) begin
        mem_q[i] <= `WORD_ZERO;
      end
    end else if (port.we && port.waddr != `REG_ZERO) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  // write-through on both ports replaces a writeback bypass
  function automatic logic [`XLEN-1:0] rd(logic [`RA_W-1:0] a);
    if (a == `REG_ZERO) begin
      rd = `WORD_ZERO;
    end else if (port.we && port.waddr == a) begin
      rd = port.wdata;
    end else begin
      rd = mem_q[a];
    end
  endfunction : rd

  // a process, not assign, so reads of storage and the write port inside rd wake it
  always_comb begin
    port.rdata_a = rd(port.raddr_a);
    port.rdata_b = rd(port.raddr_b);
  end
endmodule : reg_file
`default_nettype wire

// ### fwd_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "pipe_defines.svh"
module fwd_mux (
  input wire logic [`XLEN-1:0] rf_data, // register file read
  input wire logic m_hit, // memory stage targets source
  input wire logic [`XLEN-1:0] m_data, // memory stage result
  input wire logic a_hit, // align stage targets source
  input wire logic [`XLEN-1:0] a_data, // align stage result
  output logic [`XLEN-1:0] operand // selected operand
);
  always_comb begin
    if (m_hit) begin
      operand = m_data; // younger result wins
    end else if (a_hit) begin
      operand = a_data;
    end else begin
      operand = rf_data;
    end
  end
endmodule : fwd_mux
`default_nettype wire

// ### pipe_ctrl.sv
// How it works
// - source operands are read from the register file early in execute.
// - both operands pass a mux choosing register file, memory or align result.
// - no writeback forward; register file writes through to both read ports.
// - a consumer right after a load slips one cycle in execute.
// - consumers one or two behind a load get data via align forwarding.
// - moves from multiply or system registers behave like loads.
// - coprocessor two unusable: no transaction, raise an unusable exception.
// - coprocessor instruction word is driven on the bus in execute.
// - validation in memory stage; all coprocessor returns latched on input.
// - missing coprocessor return holds align and slips all earlier stages.
// - data from core to coprocessor is sent in the align stage.
// - completion signalled in writeback, returned data written there.
// - all branches resolve in execute, no prediction.
// - coprocessor branch does all steps in execute, slipping two or more cycles.
// - fetch TLB miss slips fetch, cache miss execute, data TLB miss memory.
// - dependencies slip execute or memory; coprocessor branch wait slips execute.
// - align slips for data cache causes or a late coprocessor return.
// - every interlock is a slip; later stages keep advancing.
// - a held stage holds earlier ones; bubbles fill the gap behind.
`timescale 1ns/10ps
`default_nettype none
`include "pipe_defines.svh"
module pipe_ctrl (
  input wire logic CLK, // pipeline clock
  input wire logic RST_N, // sync reset, low
  input wire logic DEC_VALID, // fetch stage holds an instruction
  input wire pipe_pkg::kind_t DEC_KIND, // decoded class
  input wire logic [`RA_W-1:0] DEC_SRC_A, // first source port
  input wire logic [`RA_W-1:0] DEC_SRC_B, // second source port
  input wire logic [`RA_W-1:0] DEC_DST, // destination register
  input wire logic DEC_WRITES, // writes destination
  input wire logic DEC_TO_COP2, // sends data to coprocessor
  input wire logic [`XLEN-1:0] DEC_WORD, // raw instruction word
  input wire logic [`XLEN-1:0] ALU_RESULT, // execute result
  input wire logic BRANCH_COND, // integer branch condition
  input wire logic [`XLEN-1:0] LATE_DATA, // aligned load or move data
  input wire logic COP2_USABLE, // cop_two_usable_bit
  input wire logic COP2_RET_VALID, // coprocessor return present
  input wire logic [`XLEN-1:0] COP2_RET_DATA, // coprocessor return data
  input wire logic COP2_COND_VALID, // branch condition present
  input wire logic COP2_COND, // branch condition value
  input wire logic FETCH_TLB_MISS, // fetch translation miss
  input wire logic FETCH_CACHE_MISS, // instruction cache miss
  input wire logic DATA_TLB_MISS, // data translation miss
  input wire logic E_DEP_HOLD, // multiply or tlb dependency
  input wire logic M_DEP_HOLD, // producer-consumer at memory
  input wire logic [`A_CAUSE_W-1:0] A_CAUSE_HOLD, // align stage causes
  output logic [`XLEN-1:0] OPERAND_A, // first alu operand
  output logic [`XLEN-1:0] OPERAND_B, // second alu operand
  output logic COP2_UNUSABLE_EXC, // unusable exception pulse
  output logic COP2_INSTR_VALID, // instruction on bus
  output logic [`XLEN-1:0] COP2_INSTR, // instruction bus
  output logic COP2_VALIDATE, // instruction validated
  output logic COP2_TO_VALID, // core data to coprocessor valid
  output logic [`XLEN-1:0] COP2_TO_DATA, // core data to coprocessor
  output logic COP2_COMPLETE, // instruction complete
  output logic BRANCH_TAKEN, // resolved taken, registered
  output logic [3:0] STAGE_ADVANCE // {align,memory,execute,fetch}
);
  pipe_pkg::stage_t e_q, m_q, a_q, w_q;
  pipe_pkg::stage_t dec_s, e_s, bubble;
  logic [`XLEN-1:0] word_q;
  logic ret_valid_q, cond_valid_q, cond_q, a_got_q;
  logic [`XLEN-1:0] ret_data_q;
  logic [1:0] bc_cnt_q;
  logic bc_seen_q, bc_val_q;
  logic adv_i, adv_e, adv_m, adv_a;
  logic hold_e, hold_m, hold_a;
  logic e_cop, e_bc2, e_unusable, bc2_ready, load_use, a_cop_miss;
  logic m_hit_a, m_hit_b, a_hit_a, a_hit_b;
  logic [`XLEN-1:0] a_res;

  rf_if rf ();

  reg_file u_rf (
    .clk(CLK),
    .rst_n(RST_N),
    .port(rf)
  );

  always_comb begin
    bubble = '0;
    dec_s = '0;
    dec_s.valid = DEC_VALID;
    dec_s.kind = DEC_KIND;
    dec_s.src_a = DEC_SRC_A;
    dec_s.src_b = DEC_SRC_B;
    dec_s.dst = DEC_DST;
    dec_s.wr = DEC_WRITES;
    dec_s.to_cop2 = DEC_TO_COP2;
  end

  // operands read from the file at the start of execute
  assign rf.raddr_a = e_q.src_a;
  assign rf.raddr_b = e_q.src_b;

  assign m_hit_a = pipe_pkg::hits(m_q, e_q.src_a);
  assign m_hit_b = pipe_pkg::hits(m_q, e_q.src_b);
  assign a_hit_a = pipe_pkg::hits(a_q, e_q.src_a);
  assign a_hit_b = pipe_pkg::hits(a_q, e_q.src_b);

  // late data only exists from the align stage onward
  always_comb begin
    if (a_q.kind == pipe_pkg::K_COP2) begin
      a_res = ret_valid_q ? ret_data_q : a_q.data;
    end else if (pipe_pkg::late(a_q)) begin
      a_res = LATE_DATA;
    end else begin
      a_res = a_q.data;
    end
  end

  fwd_mux u_fwd_a (
    .rf_data(rf.rdata_a),
    .m_hit(m_hit_a),
    .m_data(m_q.data),
    .a_hit(a_hit_a),
    .a_data(a_res),
    .operand(OPERAND_A)
  );

  fwd_mux u_fwd_b (
    .rf_data(rf.rdata_b),
    .m_hit(m_hit_b),
    .m_data(m_q.data),
    .a_hit(a_hit_b),
    .a_data(a_res),
    .operand(OPERAND_B)
  );

  // coprocessor returns captured every cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ret_valid_q <= 1'b0;
      ret_data_q <= `WORD_ZERO;
      cond_valid_q <= 1'b0;
      cond_q <= 1'b0;
    end else begin
      ret_valid_q <= COP2_RET_VALID;
      ret_data_q <= COP2_RET_DATA;
      cond_valid_q <= COP2_COND_VALID;
      cond_q <= COP2_COND;
    end
  end

  assign e_cop = e_q.valid && (e_q.kind == pipe_pkg::K_COP2 || e_q.kind == pipe_pkg::K_COP2_BR);
  assign e_unusable = e_cop && !COP2_USABLE;
  assign e_bc2 = e_cop && COP2_USABLE && e_q.kind == pipe_pkg::K_COP2_BR;
  // condition may only arrive after the in-execute validate step
  assign bc2_ready = (bc_cnt_q >= `BC2_MIN_SLIP) && (cond_valid_q || bc_seen_q);

  // loaded or moved value is not ready until align
  assign load_use = e_q.valid && pipe_pkg::late(m_q)
                    && (m_hit_a || m_hit_b);
  assign a_cop_miss = a_q.valid && a_q.kind == pipe_pkg::K_COP2
                      && !(ret_valid_q || a_got_q);

  assign hold_e = e_q.valid && (load_use || FETCH_CACHE_MISS || E_DEP_HOLD
                  || (e_bc2 && !bc2_ready));
  assign hold_m = m_q.valid && (DATA_TLB_MISS || M_DEP_HOLD);
  assign hold_a = a_q.valid && ((|A_CAUSE_HOLD) || a_cop_miss);

  // hold ripples upstream only; downstream keeps moving
  assign adv_a = !hold_a;
  assign adv_m = adv_a && !hold_m;
  assign adv_e = adv_m && !hold_e;
  assign adv_i = adv_e && !FETCH_TLB_MISS;
  assign STAGE_ADVANCE = {adv_a, adv_m, adv_e, adv_i};

  // unusable instruction moves on stripped of coprocessor effects
  always_comb begin
    e_s = e_q;
    if (e_unusable) begin
      e_s.kind = pipe_pkg::K_ALU;
      e_s.wr = 1'b0;
      e_s.to_cop2 = 1'b0;
    end
    e_s.data = e_q.to_cop2 ? OPERAND_B : ALU_RESULT;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      e_q <= '0;
      word_q <= `WORD_ZERO;
    end else if (adv_e) begin
      e_q <= adv_i ? dec_s : bubble;
      word_q <= DEC_WORD;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      m_q <= '0;
    end else if (adv_m) begin
      m_q <= adv_e ? e_s : bubble;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      a_q <= '0;
    end else if (adv_a) begin
      a_q <= adv_m ? m_q : bubble;
    end else if (a_q.kind == pipe_pkg::K_COP2 && ret_valid_q) begin
      a_q.data <= ret_data_q;
    end
  end

  // return seen while align slips on another cause
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      a_got_q <= 1'b0;
    end else if (adv_a) begin
      a_got_q <= 1'b0;
    end else if (a_q.kind == pipe_pkg::K_COP2 && ret_valid_q) begin
      a_got_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      w_q <= '0;
    end else begin
      w_q <= adv_a ? a_q : bubble;
      if (adv_a) begin
        w_q.data <= a_res;
      end
    end
  end

  // counts cycles spent in execute by a coprocessor branch
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bc_cnt_q <= 2'h0;
    end else if (adv_e) begin
      bc_cnt_q <= 2'h0;
    end else if (e_bc2 && bc_cnt_q != 2'h3) begin
      bc_cnt_q <= bc_cnt_q + 2'h1;
    end
  end

  // condition pulse kept while execute is held by another cause, else it is lost
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bc_seen_q <= 1'b0;
      bc_val_q <= 1'b0;
    end else if (adv_e) begin
      bc_seen_q <= 1'b0;
    end else if (e_bc2 && cond_valid_q) begin
      bc_seen_q <= 1'b1;
      bc_val_q <= cond_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BRANCH_TAKEN <= 1'b0;
    end else if (adv_e && e_bc2) begin
      BRANCH_TAKEN <= cond_valid_q ? cond_q : bc_val_q;
    end else if (adv_e && e_q.valid && e_q.kind == pipe_pkg::K_BRANCH) begin
      BRANCH_TAKEN <= BRANCH_COND;
    end else begin
      BRANCH_TAKEN <= 1'b0;
    end
  end

  // exception fires once, as the instruction leaves execute
  assign COP2_UNUSABLE_EXC = e_unusable && adv_e;
  assign COP2_INSTR_VALID = e_cop && COP2_USABLE
                            && (!e_bc2 || bc_cnt_q == 2'h0);
  assign COP2_INSTR = word_q;
  assign COP2_VALIDATE = (m_q.valid && m_q.kind == pipe_pkg::K_COP2)
                         || (e_bc2 && bc_cnt_q == 2'h1);
  assign COP2_TO_VALID = a_q.valid && a_q.kind == pipe_pkg::K_COP2 && a_q.to_cop2;
  assign COP2_TO_DATA = a_q.data;
  assign COP2_COMPLETE = w_q.valid && w_q.kind == pipe_pkg::K_COP2;

  assign rf.we = w_q.valid && w_q.wr;
  assign rf.waddr = w_q.dst;
  assign rf.wdata = w_q.data;

  a_fwd_prio: assert property (@(posedge CLK) disable iff (!RST_N)
    m_hit_a && a_hit_a |-> OPERAND_A == m_q.data)
    else $error("memory result not preferred");
  a_load_slip: assert property (@(posedge CLK) disable iff (!RST_N)
    load_use && adv_m |-> !adv_e ##1 !m_q.valid)
    else $error("load consumer not slipped");
  a_align_fwd: assert property (@(posedge CLK) disable iff (!RST_N)
    !m_hit_b && a_hit_b && a_q.kind == pipe_pkg::K_LOAD |-> OPERAND_B == LATE_DATA)
    else $error("align forward wrong");
  a_unusable_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    e_cop && !COP2_USABLE |-> !COP2_INSTR_VALID && (adv_e == COP2_UNUSABLE_EXC))
    else $error("unusable coprocessor started");
  a_cop_wait: assert property (@(posedge CLK) disable iff (!RST_N)
    a_cop_miss |-> !adv_a && !adv_m && !adv_e && !adv_i)
    else $error("missing return did not slip");
  a_bc2_slip: assert property (@(posedge CLK) disable iff (!RST_N)
    adv_e && e_bc2 |-> !$past(adv_e) && !$past(adv_e, 2))
    else $error("coprocessor branch slipped too little");
  a_bubble_fill: assert property (@(posedge CLK) disable iff (!RST_N)
    adv_a && !adv_m |=> !a_q.valid)
    else $error("no bubble behind held stage");
  a_wb_complete: assert property (@(posedge CLK) disable iff (!RST_N)
    adv_a && a_q.valid && a_q.kind == pipe_pkg::K_COP2 |=> COP2_COMPLETE && rf.wdata == $past(a_res))
    else $error("completion missing in writeback");
  a_fetch_slip: assert property (@(posedge CLK) disable iff (!RST_N)
    FETCH_TLB_MISS |-> !adv_i)
    else $error("fetch advanced on miss");
  a_rf_operand: assert property (@(posedge CLK) disable iff (!RST_N)
    e_q.valid && !m_hit_a && !a_hit_a |-> OPERAND_A == rf.rdata_a)
    else $error("operand not from register file");
  a_fwd_mem: assert property (@(posedge CLK) disable iff (!RST_N)
    m_hit_b |-> OPERAND_B == m_q.data)
    else $error("memory forward wrong");
  a_instr_bus: assert property (@(posedge CLK) disable iff (!RST_N)
    e_cop && COP2_USABLE && !e_bc2 |-> COP2_INSTR_VALID && COP2_INSTR == word_q)
    else $error("instruction not on bus in execute");
  a_validate_mem: assert property (@(posedge CLK) disable iff (!RST_N)
    m_q.valid && m_q.kind == pipe_pkg::K_COP2 |-> COP2_VALIDATE)
    else $error("validate missing in memory stage");
  a_ret_latch: assert property (@(posedge CLK) disable iff (!RST_N)
    COP2_RET_VALID |=> ret_valid_q && ret_data_q == $past(COP2_RET_DATA))
    else $error("return not latched");
  a_send_data: assert property (@(posedge CLK) disable iff (!RST_N)
    adv_m && adv_e && e_s.to_cop2 |=> m_q.data == $past(OPERAND_B))
    else $error("send data not captured");
  a_branch_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    adv_e && e_q.valid && e_q.kind == pipe_pkg::K_BRANCH |=> BRANCH_TAKEN == $past(BRANCH_COND))
    else $error("branch not resolved in execute");
  a_exec_slip: assert property (@(posedge CLK) disable iff (!RST_N)
    e_q.valid && FETCH_CACHE_MISS |-> !adv_e && !adv_i)
    else $error("execute advanced on cache miss");
  a_mem_slip: assert property (@(posedge CLK) disable iff (!RST_N)
    m_q.valid && DATA_TLB_MISS |-> !adv_m && !adv_e)
    else $error("memory advanced on data miss");
  a_dep_slip: assert property (@(posedge CLK) disable iff (!RST_N)
    e_q.valid && E_DEP_HOLD |-> !adv_e)
    else $error("execute advanced on dependency");
  a_align_slip: assert property (@(posedge CLK) disable iff (!RST_N)
    a_q.valid && (|A_CAUSE_HOLD) |-> !adv_a)
    else $error("align advanced on hold cause");
  a_slip_only: assert property (@(posedge CLK) disable iff (!RST_N)
    hold_e && !hold_m && !hold_a |-> adv_m && adv_a)
    else $error("later stages stalled");
endmodule : pipe_ctrl
`default_nettype wire

// ### cop2_model.sv
`timescale 1ns/10ps
`default_nettype none
module cop2_model (
  input wire logic clk, // pipeline clock
  input wire logic validate, // core validated an instruction
  input wire logic m_new, // a new instruction entered memory
  input wire logic br, // answer with a branch condition
  input wire logic cond_in, // condition to return
  input wire logic [3:0] dly, // return delay in cycles
  input wire logic [31:0] word, // data to return
  output logic ret_valid, // return present
  output logic [31:0] ret_data, // return data
  output logic cond_valid, // condition present
  output logic cond // condition value
);
  logic seen_q;
  logic busy;
  logic fire;
  logic [3:0] cnt;
  initial begin
    ret_valid = 1'b0;
    ret_data = 32'h0;
    cond_valid = 1'b0;
    cond = 1'b0;
    seen_q = 1'b0;
    busy = 1'b0;
    cnt = 4'h0;
  end
  // lines toggle outside the pulse so a stale value never passes for a return
  always @(negedge clk) begin
    fire = 1'b0;
    if (validate && (!seen_q || m_new)) begin
      busy = 1'b1;
      cnt = dly;
    end
    seen_q = validate;
    if (busy && cnt == 4'h0) begin
      busy = 1'b0;
      fire = 1'b1;
    end else if (busy) begin
      cnt = cnt - 4'h1;
    end
    ret_valid <= fire && !br;
    cond_valid <= fire && br;
    ret_data <= fire ? word : ~ret_data;
    cond <= fire ? cond_in : ~cond;
  end
endmodule : cop2_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pipe_defines.svh"
module tb_top;
  logic CLK;
  logic RST_N = 1'b0, DEC_VALID = 1'b0, DEC_WRITES = 1'b0, DEC_TO_COP2 = 1'b0;
  logic BRANCH_COND = 1'b0, COP2_USABLE = 1'b1, E_DEP_HOLD = 1'b0, M_DEP_HOLD = 1'b0;
  logic FETCH_TLB_MISS = 1'b0, FETCH_CACHE_MISS = 1'b0, DATA_TLB_MISS = 1'b0;
  pipe_pkg::kind_t DEC_KIND = pipe_pkg::K_ALU;
  logic [`RA_W-1:0] DEC_SRC_A = 5'h0, DEC_SRC_B = 5'h0, DEC_DST = 5'h0;
  logic [`XLEN-1:0] DEC_WORD = 32'h0, ALU_RESULT, LATE_DATA, COP2_RET_DATA;
  logic [`XLEN-1:0] OPERAND_A, OPERAND_B, COP2_INSTR, COP2_TO_DATA;
  logic [`A_CAUSE_W-1:0] A_CAUSE_HOLD = 7'h00;
  logic COP2_RET_VALID, COP2_COND_VALID, COP2_COND, COP2_UNUSABLE_EXC, COP2_INSTR_VALID;
  logic COP2_VALIDATE, COP2_TO_VALID, COP2_COMPLETE, BRANCH_TAKEN;
  logic [3:0] STAGE_ADVANCE;
  logic m_new = 1'b0, br = 1'b0, cond_in = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [31:0] ret_w = 32'h0;
  int num_errors = 0;
  int total_checks = 0;
  // simple external alu: result depends on the forwarded operand
  assign ALU_RESULT = OPERAND_A + 32'h11;
  assign LATE_DATA = 32'h5a5a;
  pipe_ctrl pipe_ctrl_inst (.CLK, .RST_N, .DEC_VALID, .DEC_KIND, .DEC_SRC_A, .DEC_SRC_B,
    .DEC_DST, .DEC_WRITES, .DEC_TO_COP2, .DEC_WORD, .ALU_RESULT, .BRANCH_COND, .LATE_DATA,
    .COP2_USABLE, .COP2_RET_VALID, .COP2_RET_DATA, .COP2_COND_VALID, .COP2_COND,
    .FETCH_TLB_MISS, .FETCH_CACHE_MISS, .DATA_TLB_MISS, .E_DEP_HOLD, .M_DEP_HOLD,
    .A_CAUSE_HOLD, .OPERAND_A, .OPERAND_B, .COP2_UNUSABLE_EXC, .COP2_INSTR_VALID,
    .COP2_INSTR, .COP2_VALIDATE, .COP2_TO_VALID, .COP2_TO_DATA, .COP2_COMPLETE,
    .BRANCH_TAKEN, .STAGE_ADVANCE);
  cop2_model cop2_model_inst (.clk(CLK), .validate(COP2_VALIDATE), .m_new, .br, .cond_in,
    .dly, .word(ret_w), .ret_valid(COP2_RET_VALID), .ret_data(COP2_RET_DATA),
    .cond_valid(COP2_COND_VALID), .cond(COP2_COND));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) m_new <= STAGE_ADVANCE[1];
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task stop_test;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task idle(input int n);
    DEC_VALID = 1'b0;
    repeat (n) @(negedge CLK);
  endtask : idle
  // offers one instruction, returns at the negedge where it leaves execute
  task issue(input pipe_pkg::kind_t k, input logic [4:0] a, input logic [4:0] b,
             input logic [4:0] d, input logic w, input logic [31:0] ea, input logic [31:0] eb,
             input logic [3:0] es);
    int n;
    int s;
    DEC_VALID = 1'b1;
    DEC_KIND = k;
    DEC_SRC_A = a;
    DEC_SRC_B = b;
    DEC_DST = d;
    DEC_WRITES = w;
    n = 0;
    s = 0;
    #1;
    while (STAGE_ADVANCE[0] !== 1'b1 && n < 20) begin
      @(negedge CLK);
      #1;
      n++;
    end
    @(negedge CLK);
    while (STAGE_ADVANCE[1] !== 1'b1 && s < 20) begin
      @(negedge CLK);
      s++;
    end
    check(OPERAND_A, ea);
    check(OPERAND_B, eb);
    check(s, es);
  endtask : issue
  task t_fwd;
    issue(pipe_pkg::K_ALU, 5'h0, 5'h0, 5'h3, 1'b1, 32'h0, 32'h0, 4'h0);
    issue(pipe_pkg::K_ALU, 5'h3, 5'h0, 5'h3, 1'b1, 32'h11, 32'h0, 4'h0);
    issue(pipe_pkg::K_ALU, 5'h3, 5'h3, 5'h4, 1'b1, 32'h22, 32'h22, 4'h0);
    issue(pipe_pkg::K_ALU, 5'h4, 5'h3, 5'h5, 1'b0, 32'h33, 32'h22, 4'h0);
    issue(pipe_pkg::K_ALU, 5'h3, 5'h4, 5'h5, 1'b0, 32'h22, 32'h33, 4'h0);
    issue(pipe_pkg::K_ALU, 5'h3, 5'h4, 5'h0, 1'b0, 32'h22, 32'h33, 4'h0);
  endtask : t_fwd
  task t_late;
    for (int i = 1; i < 4; i++) begin
      issue(pipe_pkg::kind_t'(i), 5'h0, 5'h0, 5'h6, 1'b1, 32'h0, 32'h0, 4'h0);
      issue(pipe_pkg::K_ALU, 5'h6, 5'h0, 5'h0, 1'b0, 32'h5a5a, 32'h0, 4'h1);
      issue(pipe_pkg::kind_t'(i), 5'h0, 5'h0, 5'h7, 1'b1, 32'h0, 32'h0, 4'h0);
      issue(pipe_pkg::K_ALU, 5'h0, 5'h0, 5'h0, 1'b0, 32'h0, 32'h0, 4'h0);
      issue(pipe_pkg::K_ALU, 5'h0, 5'h7, 5'h0, 1'b0, 32'h0, 32'h5a5a, 4'h0);
    end
  endtask : t_late
  task t_hold;
    repeat (4) issue(pipe_pkg::K_ALU, 5'h0, 5'h0, 5'h0, 1'b0, 32'h0, 32'h0, 4'h0);
    for (int i = 0; i < 11; i++) begin
      for (int j = 0; j < 5; j++) begin
        FETCH_TLB_MISS = (i == 0 && j == 0);
        FETCH_CACHE_MISS = (i == 1 && j == 0);
        E_DEP_HOLD = (i == 2 && j == 0);
        DATA_TLB_MISS = (i == 3 && j == 0);
        M_DEP_HOLD = (i == 4 && j == 0);
        A_CAUSE_HOLD = (i > 4 && j == 0) ? 7'h01 << (i - 5) : 7'h00;
        #1;
        if (j == 0)
          check(STAGE_ADVANCE, i == 0 ? 4'he : i < 3 ? 4'hc : i < 5 ? 4'h8 : 4'h0);
        @(negedge CLK);
      end
    end
  endtask : t_hold
  task t_cop2(input logic [3:0] dl, input logic to, input logic [4:0] b, input logic [31:0] eb,
              input logic [31:0] wd);
    DEC_TO_COP2 = to;
    DEC_WORD = wd;
    ret_w = ~wd;
    dly = dl;
    br = 1'b0;
    issue(pipe_pkg::K_COP2, 5'h0, b, 5'h8, 1'b1, 32'h0, eb, 4'h0);
    check(COP2_INSTR_VALID, 1'b1);
    check(COP2_INSTR, wd);
    idle(1);
    check(COP2_VALIDATE, 1'b1);
    idle(1);
    repeat (dl) begin
      check(STAGE_ADVANCE, 4'h0);
      idle(1);
    end
    check(STAGE_ADVANCE[3], 1'b1);
    check(COP2_TO_VALID, to);
    if (to)
      check(COP2_TO_DATA, eb);
    idle(1);
    check(COP2_COMPLETE, 1'b1);
    DEC_TO_COP2 = 1'b0;
    issue(pipe_pkg::K_ALU, 5'h8, 5'h0, 5'h0, 1'b0, ~wd, 32'h0, 4'h0);
  endtask : t_cop2
  task t_unusable;
    COP2_USABLE = 1'b0;
    issue(pipe_pkg::K_COP2, 5'h0, 5'h0, 5'h9, 1'b1, 32'h0, 32'h0, 4'h0);
    check(COP2_UNUSABLE_EXC, 1'b1);
    check(COP2_INSTR_VALID, 1'b0);
    idle(1);
    check(COP2_VALIDATE, 1'b0);
    idle(3);
    COP2_USABLE = 1'b1;
  endtask : t_unusable
  task t_branch;
    br = 1'b1;
    dly = 4'h3;
    cond_in = 1'b1;
    issue(pipe_pkg::K_COP2_BR, 5'h0, 5'h0, 5'h0, 1'b0, 32'h0, 32'h0, 4'h5);
    idle(1);
    check(BRANCH_TAKEN, 1'b1);
    dly = 4'h0;
    cond_in = 1'b0;
    issue(pipe_pkg::K_COP2_BR, 5'h0, 5'h0, 5'h0, 1'b0, 32'h0, 32'h0, 4'h2);
    idle(1);
    check(BRANCH_TAKEN, 1'b0);
    br = 1'b0;
    BRANCH_COND = 1'b1;
    issue(pipe_pkg::K_BRANCH, 5'h0, 5'h0, 5'h0, 1'b0, 32'h0, 32'h0, 4'h0);
    idle(1);
    check(BRANCH_TAKEN, 1'b1);
    BRANCH_COND = 1'b0;
  endtask : t_branch
  initial begin
    #300000;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (6) @(negedge CLK);
    RST_N = 1'b1;
    idle(1);
    t_fwd;
    t_late;
    t_hold;
    t_cop2(4'h0, 1'b0, 5'h0, 32'h0, 32'hc0de_0001);
    t_cop2(4'h2, 1'b1, 5'h8, 32'h3f21_fffe, 32'hc0de_0002);
    t_unusable;
    t_branch;
    idle(4);
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
